// ### core/ddr3_spacing_defs.svh
// Timing figures, command codes and reset values for the DDR3 host.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef DDR3_SPACING_DEFS_SVH
`define DDR3_SPACING_DEFS_SVH

// System clock period in ps
`define SYS_CLK_PS    5000
// Spacing floors in memory clocks and time minimums in ps
`define T_MRD_CK      4
`define T_MOD_CK      12
`define T_MOD_PS      15000
`define T_CCD_CK      4
`define T_MPRR_CK     1
`define T_RRD_CK      4
`define T_RRD_LO_PS   7500
`define T_RRD_HI_PS   6000
`define T_FAW_LO_PS   40000
`define T_FAW_HI_PS   35000
`define T_RTP_CK      4
`define T_RTP_PS      7500
`define T_WTR_CK      4
`define T_WTR_PS      7500
`define T_WR_PS       15000
`define BURST_BEATS   8
// Command pin codes {cs_n, ras_n, cas_n, we_n}
`define CMD_MRS       4'h0
`define CMD_ACT       4'h3
`define CMD_RD        4'h5
`define CMD_WR        4'h4
`define CMD_PRE       4'h2
`define CMD_NOP       4'h7
// Auto-precharge address bit
`define AP_BIT        10
// Reset value of counters
`define CNT_RST       8'h00

`endif

// ### core/ddr3_spacing_host.sv
// DDR3 host: spaces user commands, makes the memory clock, frames strobes.
// Assumes one system clock, a user holding req_valid until req_ready, and
// a bench that resolves the strobe and data wires from the enables.
`timescale 1ns/1ps
`default_nettype none
`include "ddr3_spacing_defs.svh"

module ddr3_spacing_host #(
	parameter int CK_HALF  = 2,
	parameter int CNT_W    = 8,
	parameter int CL       = 5,
	parameter int CWL      = 5,
	parameter bit SPEED_HI = 1'b0,
	parameter int RP_PS    = 15000
)(
	input  wire  logic                     sys_clk,
	input  wire  logic                     resetn,
	input  wire  logic                     req_valid,
	input  wire  ddr3_spacing_pkg::req_s   req,
	output logic                           req_ready,
	input  wire  logic [127:0]             wr_data,
	output logic                           rd_valid,
	output logic [127:0]                   rd_data,
	output logic                           ck,
	output ddr3_spacing_pkg::cmd_s         cmd,
	output logic                           dqs_o,
	output logic                           dqs_oe,
	input  wire  logic                     dqs_i,
	output logic [15:0]                    dq_o,
	output logic                           dq_oe,
	input  wire  logic [15:0]              dq_i
);
	import ddr3_spacing_pkg::*;

	localparam int TCK_PS = 2 * CK_HALF * `SYS_CLK_PS;

	// Time minimum to clocks, rounded up, raised to the floor
	function automatic int ck_cyc(input int ps, input int floor_ck);
		int c;
		c = (ps + TCK_PS - 1) / TCK_PS;
		return (c > floor_ck) ? c : floor_ck;
	endfunction

	// Count down one step on a memory clock tick
	function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] x,
		input logic t);
		return (t && x != '0) ? x - 1'b1 : x;
	endfunction

	// Request to command pins
	function automatic cmd_s enc(input req_s r);
		cmd_s c;
		c.ba = r.ba;
		c.addr = r.addr;
		case (r.op)
			OP_MRS, OP_MPR_EXIT: {c.cs_n, c.ras_n, c.cas_n, c.we_n} = `CMD_MRS;
			OP_ACT:              {c.cs_n, c.ras_n, c.cas_n, c.we_n} = `CMD_ACT;
			OP_RD:               {c.cs_n, c.ras_n, c.cas_n, c.we_n} = `CMD_RD;
			OP_WR, OP_WRA:       {c.cs_n, c.ras_n, c.cas_n, c.we_n} = `CMD_WR;
			OP_PRE:              {c.cs_n, c.ras_n, c.cas_n, c.we_n} = `CMD_PRE;
			default:             {c.cs_n, c.ras_n, c.cas_n, c.we_n} = `CMD_NOP;
		endcase
		if (r.op == OP_WRA)
			c.addr[`AP_BIT] = 1'b1;
		else if (r.op == OP_WR)
			c.addr[`AP_BIT] = 1'b0;
		return c;
	endfunction

	localparam int BL2    = `BURST_BEATS / 2;
	localparam int MRD    = `T_MRD_CK;
	localparam int MOD    = ck_cyc(`T_MOD_PS, `T_MOD_CK);
	localparam int CCD    = `T_CCD_CK;
	localparam int MPRR   = `T_MPRR_CK;
	localparam int RRD    = ck_cyc(SPEED_HI ? `T_RRD_HI_PS : `T_RRD_LO_PS,
		`T_RRD_CK);
	localparam int FAW    = ck_cyc(SPEED_HI ? `T_FAW_HI_PS : `T_FAW_LO_PS, 1);
	localparam int RTP    = ck_cyc(`T_RTP_PS, `T_RTP_CK);
	localparam int WTR    = CWL + BL2 + ck_cyc(`T_WTR_PS, `T_WTR_CK);
	localparam int WR_CK  = ck_cyc(`T_WR_PS, 1);
	localparam int DAL    = CWL + BL2 + WR_CK + ck_cyc(RP_PS, 1);
	// Data update phase, half a half clock away from the strobe edges
	localparam int MID    = CK_HALF / 2;
	// Strobe windows in half memory clocks after the command
	localparam logic [CNT_W-1:0] W_ON  = CNT_W'(2 * CWL - 1);
	localparam logic [CNT_W-1:0] W_D0  = CNT_W'(2 * CWL + 1);
	localparam logic [CNT_W-1:0] W_D7  = CNT_W'(2 * CWL + `BURST_BEATS);
	localparam logic [CNT_W-1:0] W_OFF = CNT_W'(2 * CWL + `BURST_BEATS + 2);
	localparam logic [CNT_W-1:0] R_ON  = CNT_W'(2 * CL - 1);
	localparam logic [CNT_W-1:0] R_END = CNT_W'(2 * CL + `BURST_BEATS + 4);

	logic [CNT_W-1:0] ph_r, ph_nxt;
	logic             ck_r, ck_nxt, ck_o_r;
	logic             half_end, tick;

	// Memory clock divider
	always_comb
	begin
		half_end = (ph_r == CNT_W'(CK_HALF - 1));
		tick = half_end && ck_r;
		ph_nxt = half_end ? '0 : ph_r + 1'b1;
		ck_nxt = half_end ? ~ck_r : ck_r;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ph_r <= `CNT_RST;
			ck_r <= 1'b0;
			ck_o_r <= 1'b0;
		end
		else
		begin
			ph_r <= ph_nxt;
			ck_r <= ck_nxt;
			ck_o_r <= ck_r;
		end
	end

	logic        dqs_s1, dqs_s2, dqs_s3, dqs_s4;
	logic [15:0] dq_s1, dq_s2;

	// Pin synchronisers, read side
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			{dqs_s1, dqs_s2, dqs_s3, dqs_s4} <= 4'h0;
			dq_s1 <= 16'h0000;
			dq_s2 <= 16'h0000;
		end
		else
		begin
			{dqs_s1, dqs_s2, dqs_s3, dqs_s4} <= {dqs_i, dqs_s1, dqs_s2, dqs_s3};
			dq_s1 <= dq_i;
			dq_s2 <= dq_s1;
		end
	end

	logic [CNT_W-1:0] mrd_r, mod_r, ccd_r, mprr_r, rrd_r, wtr_r;
	logic [CNT_W-1:0] mrd_nxt, mod_nxt, ccd_nxt, mprr_nxt, rrd_nxt, wtr_nxt;
	logic [CNT_W-1:0] faw_r [4];
	logic [CNT_W-1:0] faw_nxt [4];
	logic [CNT_W-1:0] dal_r [8];
	logic [CNT_W-1:0] dal_nxt [8];
	logic [CNT_W-1:0] rtp_r [8];
	logic [CNT_W-1:0] rtp_nxt [8];
	logic [1:0]       fptr_r, fptr_nxt;
	burst_e           st_r, st_nxt;
	logic             gen_ok, legal, go, req_ready_r;

	// Legality of the waiting request
	always_comb
	begin
		gen_ok = (mod_r == '0) && (mprr_r == '0);
		case (req.op)
			OP_MRS, OP_MPR_EXIT:
				legal = (mrd_r == '0) && (mprr_r == '0) && st_r == B_IDLE;
			OP_ACT:
				legal = gen_ok && (rrd_r == '0)
					&& (faw_r[fptr_r] == '0)
					&& (dal_r[req.ba] == '0);
			OP_RD:
				legal = gen_ok && (ccd_r == '0) && (wtr_r == '0)
					&& st_r == B_IDLE;
			OP_WR, OP_WRA:
				legal = gen_ok && (ccd_r == '0) && st_r == B_IDLE;
			OP_PRE:
				legal = gen_ok && (rtp_r[req.ba] == '0);
			default:
				legal = 1'b0;
		endcase
		go = tick && req_valid && legal && !req_ready_r;
	end

	// Spacing counters, one step per memory clock
	always_comb
	begin
		mrd_nxt = dec(mrd_r, tick);
		mod_nxt = dec(mod_r, tick);
		ccd_nxt = dec(ccd_r, tick);
		mprr_nxt = dec(mprr_r, tick);
		rrd_nxt = dec(rrd_r, tick);
		wtr_nxt = dec(wtr_r, tick);
		fptr_nxt = fptr_r;
		for (int i = 0; i < 4; i++)
			faw_nxt[i] = dec(faw_r[i], tick);
		for (int i = 0; i < 8; i++)
		begin
			dal_nxt[i] = dec(dal_r[i], tick);
			rtp_nxt[i] = dec(rtp_r[i], tick);
		end
		if (go)
		begin
			case (req.op)
				OP_MRS, OP_MPR_EXIT:
				begin
					mrd_nxt = CNT_W'(MRD);
					mod_nxt = CNT_W'(MOD);
					if (req.op == OP_MPR_EXIT)
						mprr_nxt = CNT_W'(MPRR);
				end
				OP_ACT:
				begin
					rrd_nxt = CNT_W'(RRD);
					faw_nxt[fptr_r] = CNT_W'(FAW);
					fptr_nxt = fptr_r + 1'b1;
				end
				OP_RD:
				begin
					ccd_nxt = CNT_W'(CCD);
					rtp_nxt[req.ba] = CNT_W'(RTP);
				end
				OP_WR, OP_WRA:
				begin
					ccd_nxt = CNT_W'(CCD);
					wtr_nxt = CNT_W'(WTR);
					if (req.op == OP_WRA)
						dal_nxt[req.ba] = CNT_W'(DAL);
				end
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mrd_r <= `CNT_RST;
			mod_r <= `CNT_RST;
			ccd_r <= `CNT_RST;
			mprr_r <= `CNT_RST;
			rrd_r <= `CNT_RST;
			wtr_r <= `CNT_RST;
			fptr_r <= 2'h0;
			for (int i = 0; i < 4; i++)
				faw_r[i] <= `CNT_RST;
			for (int i = 0; i < 8; i++)
			begin
				dal_r[i] <= `CNT_RST;
				rtp_r[i] <= `CNT_RST;
			end
		end
		else
		begin
			mrd_r <= mrd_nxt;
			mod_r <= mod_nxt;
			ccd_r <= ccd_nxt;
			mprr_r <= mprr_nxt;
			rrd_r <= rrd_nxt;
			wtr_r <= wtr_nxt;
			fptr_r <= fptr_nxt;
			faw_r <= faw_nxt;
			dal_r <= dal_nxt;
			rtp_r <= rtp_nxt;
		end
	end

	logic [CNT_W-1:0] hc_r, hc_nxt;
	logic [3:0]       beat_r, beat_nxt;
	logic [127:0]     wbuf_r, wbuf_nxt, rsh_r, rsh_nxt, rd_data_r, rd_data_nxt;
	logic             rd_valid_r, rd_valid_nxt;
	logic             dqs_o_r, dqs_o_nxt, dqs_oe_r, dqs_oe_nxt, dq_oe_r;
	logic [15:0]      dq_o_r, dq_o_nxt;
	cmd_s             cmd_r, cmd_nxt;

	// Command pins, burst framing and read capture
	always_comb
	begin
		st_nxt = st_r;
		hc_nxt = half_end ? hc_r + 1'b1 : hc_r;
		beat_nxt = beat_r;
		wbuf_nxt = wbuf_r;
		rsh_nxt = rsh_r;
		rd_data_nxt = rd_data_r;
		rd_valid_nxt = 1'b0;
		dqs_o_nxt = 1'b0;
		dqs_oe_nxt = 1'b0;
		dq_o_nxt = dq_o_r;
		cmd_nxt = cmd_r;
		if (tick)
			cmd_nxt = enc('{op: OP_NOP, ba: 3'h0, addr: 13'h0000});
		if (go)
			cmd_nxt = enc(req);
		case (st_r)
			B_IDLE:
			begin
				hc_nxt = '0;
				if (go && (req.op == OP_WR || req.op == OP_WRA))
				begin
					st_nxt = B_WRITE;
					wbuf_nxt = wr_data;
				end
				else if (go && req.op == OP_RD)
				begin
					st_nxt = B_READ;
					beat_nxt = 4'h0;
				end
			end
			B_WRITE:
			begin
				// Low preamble, toggles with ck, low postamble
				dqs_oe_nxt = (hc_r >= W_ON) && (hc_r < W_OFF);
				dqs_o_nxt = (hc_r >= W_D0) && (hc_r <= W_D7) && hc_r[0];
				if (hc_r >= W_D0 - 1'b1 && hc_r < W_D7 && ph_r == CNT_W'(MID))
				begin
					dq_o_nxt = wbuf_r[15:0];
					wbuf_nxt = {16'h0000, wbuf_r[127:16]};
				end
				if (hc_r == W_OFF)
					st_nxt = B_IDLE;
			end
			B_READ:
			begin
				// Strobe left to the memory for the whole window
				// First beat only on a rising edge: the preamble's fall
				// out of a released wire is not data
				if (hc_r >= R_ON && (dqs_s3 ^ dqs_s4)
					&& (beat_r != 4'h0 || dqs_s3))
				begin
					rsh_nxt = {dq_s2, rsh_r[127:16]};
					beat_nxt = beat_r + 1'b1;
					if (beat_r == 4'(`BURST_BEATS - 1))
					begin
						rd_valid_nxt = 1'b1;
						rd_data_nxt = {dq_s2, rsh_r[127:16]};
					end
				end
				if (hc_r == R_END)
					st_nxt = B_IDLE;
			end
			default:
				st_nxt = B_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_r <= B_IDLE;
			hc_r <= `CNT_RST;
			beat_r <= 4'h0;
			wbuf_r <= '0;
			rsh_r <= '0;
			rd_data_r <= '0;
			rd_valid_r <= 1'b0;
			dqs_o_r <= 1'b0;
			dqs_oe_r <= 1'b0;
			dq_oe_r <= 1'b0;
			dq_o_r <= 16'h0000;
			cmd_r <= {`CMD_NOP, 3'h0, 13'h0000};
			req_ready_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			hc_r <= hc_nxt;
			beat_r <= beat_nxt;
			wbuf_r <= wbuf_nxt;
			rsh_r <= rsh_nxt;
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
			dqs_o_r <= dqs_o_nxt;
			dqs_oe_r <= dqs_oe_nxt;
			dq_oe_r <= dqs_oe_nxt;
			dq_o_r <= dq_o_nxt;
			cmd_r <= cmd_nxt;
			req_ready_r <= go;
		end
	end

	// Output pins
	assign ck = ck_o_r;
	assign cmd = cmd_r;
	assign req_ready = req_ready_r;
	assign rd_valid = rd_valid_r;
	assign rd_data = rd_data_r;
	assign dqs_o = dqs_o_r;
	assign dqs_oe = dqs_oe_r;
	assign dq_o = dq_o_r;
	assign dq_oe = dq_oe_r;

endmodule // ddr3_spacing_host
`default_nettype wire

// ### core/ddr3_spacing_pkg.sv
// Types shared by the DDR3 command spacing host and its bench.
// Assumes nothing of its surroundings.
package ddr3_spacing_pkg;

	typedef enum logic [2:0] {
		OP_NOP, OP_MRS, OP_MPR_EXIT, OP_ACT, OP_RD, OP_WR, OP_WRA, OP_PRE
	} op_e;

	// User request
	typedef struct packed {
		op_e         op;
		logic [2:0]  ba;
		logic [12:0] addr;
	} req_s;

	// Command pins towards the memory
	typedef struct packed {
		logic        cs_n;
		logic        ras_n;
		logic        cas_n;
		logic        we_n;
		logic [2:0]  ba;
		logic [12:0] addr;
	} cmd_s;

	typedef enum logic [1:0] {B_IDLE, B_WRITE, B_READ} burst_e;

endpackage

// ### verif/ddr3_mem_model.sv
// Memory model: stores the last write burst, returns it on reads.
// Assumes the bench resolves strobe and data wires from all enables.
`timescale 1ns/1ps
`default_nettype none
`include "ddr3_spacing_defs.svh"

module ddr3_mem_model #(
	parameter int CL = 5
)(
	input  wire logic                   ck,
	input  wire ddr3_spacing_pkg::cmd_s cmd,
	input  wire logic                   dqs_w,
	input  wire logic [15:0]            dq_w,
	input  wire logic                   host_oe,
	output logic                        m_dqs,
	output logic                        m_oe,
	output logic [15:0]                 m_dq
);
	import ddr3_spacing_pkg::*;
	logic [127:0] mem_r = '0;
	int           rk = 0;

	initial
	begin
		m_dqs = 1'b0;
		m_oe = 1'b0;
		m_dq = '0;
	end

	// Keep the last eight beats the host strobes in; look just after the
	// edge so a strobe released in the same step is not taken as a beat
	always @(posedge dqs_w or negedge dqs_w)
	begin
		#1;
		if (host_oe)
			mem_r <= {dq_w, mem_r[127:16]};
	end

	// Clocks since a read: preamble, rising beats, release
	always @(posedge ck)
	begin
		if ({cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} == `CMD_RD)
			rk <= 1;
		else if (rk != 0)
			rk <= (rk == CL + 4) ? 0 : rk + 1;
		if (rk == CL - 1)
		begin
			m_oe <= 1'b1;
			m_dqs <= 1'b0;
		end
		if (rk >= CL && rk < CL + 4)
		begin
			m_dqs <= 1'b1;
			m_dq <= mem_r[32 * (rk - CL) +: 16];
		end
		if (rk == CL + 4)
			m_oe <= 1'b0;
	end

	// Falling beats
	always @(negedge ck)
		if (rk > CL && rk <= CL + 4)
		begin
			m_dqs <= 1'b0;
			m_dq <= mem_r[32 * (rk - CL) - 16 +: 16];
		end
endmodule // ddr3_mem_model
`default_nettype wire

// ### verif/ddr3_spacing_host_tb.sv
// Testbench for the DDR3 host with the memory model on its pins.
// Assumes the host defaults of two system cycles per memory clock half.
`timescale 1ns/1ps
`default_nettype none
`include "ddr3_spacing_defs.svh"

module ddr3_spacing_host_tb;
	import ddr3_spacing_pkg::*;
	localparam int CL = 5;
	localparam int CWL = 5;
	localparam int RP = 15000;
	localparam int TCK_PS = 4 * `SYS_CLK_PS;
	logic sys_clk = 1'b0;
	logic resetn, req_valid, req_ready, rd_valid, ck;
	logic dqs_o, dqs_oe, dq_oe, dqs_w, m_dqs, m_oe;
	logic fl = 1'b1;
	logic [15:0] dq_o, dq_w, m_dq;
	logic [127:0] wr_data, rd_data, exp_d;
	logic [3:0] code;
	logic [2:0] b;
	req_s req;
	cmd_s cmd;
	int bad_count = 0;
	int compares = 0;
	int seed = 14087;
	int cyc = 0;
	int t_wr = -9999;
	int t_rd[8] = '{default: -9999};
	int t_wra[8] = '{default: -9999};
	int acts[$];
	op_e seq_op[14] = '{OP_MRS, OP_MRS, OP_MPR_EXIT, OP_ACT, OP_ACT, OP_ACT,
		OP_ACT, OP_ACT, OP_WR, OP_RD, OP_PRE, OP_WRA, OP_ACT, OP_RD};
	logic [2:0] seq_ba[14] = '{0, 0, 0, 0, 1, 2, 3, 4, 0, 0, 0, 1, 1, 1};

	always #2.5 sys_clk = ~sys_clk;

	// Wires: released strobe flips its last level, data runs a pattern
	assign dqs_w = dqs_oe ? dqs_o : (m_oe ? m_dqs : fl);
	assign dq_w = dq_oe ? dq_o : (m_oe ? m_dq : 16'(cyc));
	assign code = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
	always @(posedge sys_clk)
		if (dqs_oe || m_oe)
			fl <= ~dqs_w;

	ddr3_spacing_host #(.CL(CL), .CWL(CWL), .RP_PS(RP)) dut (
		.sys_clk, .resetn, .req_valid, .req, .req_ready, .wr_data,
		.rd_valid, .rd_data, .ck, .cmd, .dqs_o, .dqs_oe, .dqs_i(dqs_w),
		.dq_o, .dq_oe, .dq_i(dq_w)
	);
	ddr3_mem_model #(.CL(CL)) mem (
		.ck, .cmd, .dqs_w, .dq_w, .host_oe(dqs_oe), .m_dqs, .m_oe, .m_dq
	);

	// System cycles for a time minimum in whole memory clocks, raised to its floor
	function automatic int gap(input int ck_n, input int ps);
		int n;
		n = (ps + TCK_PS - 1) / TCK_PS;
		return 4 * ((n > ck_n) ? n : ck_n);
	endfunction

	task automatic chk(input string nm, input logic [127:0] e,
		input logic [127:0] s);
		compares++;
		if (s !== e)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic span(input string nm, input int t, input int need);
		chk(nm, 128'h1, 128'(cyc - t >= need));
	endtask

	task automatic results;
		if (bad_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// One request held until taken; reads wait for their burst
	task automatic issue(input op_e op, input logic [2:0] ba);
		int i;
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req <= '{op, ba, 13'($random(seed))};
		wr_data <= {$random(seed), $random(seed), $random(seed), $random(seed)};
		for (i = 0; i < 400; i++)
		begin
			@(negedge sys_clk);
			if (req_ready)
				break;
		end
		@(posedge sys_clk);
		req_valid <= 1'b0;
		if (op == OP_WR || op == OP_WRA)
			exp_d = wr_data;
		for (i = (i == 400) ? 400 : 0; i < 100; i++)
		begin
			@(negedge sys_clk);
			if (op != OP_RD || rd_valid)
				break;
		end
		if (i >= 100)
		begin
			bad_count++;
			results();
		end
		if (op == OP_RD)
			chk("rd_data", exp_d, rd_data);
	endtask

	// Gaps before each precharge, read and activate the host puts out
	always @(negedge sys_clk)
	begin
		cyc++;
		b = cmd.ba;
		if (req_ready)
			case (code)
				`CMD_PRE: span("rd to pre", t_rd[b], gap(`T_RTP_CK, `T_RTP_PS));
				`CMD_RD:
				begin
					span("wr to rd", t_wr, gap(CWL + 4, 0) + gap(`T_WTR_CK, `T_WTR_PS));
					t_rd[b] = cyc;
				end
				`CMD_WR:
				begin
					t_wr = cyc;
					if (cmd.addr[`AP_BIT])
						t_wra[b] = cyc;
				end
				`CMD_ACT:
				begin
					span("wra to act", t_wra[b], gap(CWL + 4, 0) + gap(0, `T_WR_PS) + gap(0, RP));
					if (acts.size() == 4)
						span("four act", acts.pop_front(), gap(0, `T_FAW_LO_PS));
					acts.push_back(cyc);
				end
				default: ;
			endcase
	end

	initial
	begin
		resetn = 1'b0;
		req_valid = 1'b0;
		req = '0;
		wr_data = '0;
		exp_d = '0;
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		// Corner cases first, then random traffic
		foreach (seq_op[k])
			issue(seq_op[k], seq_ba[k]);
		repeat (40)
			issue(op_e'(1 + $unsigned($random(seed)) % 7), 3'($random(seed)));
		results();
	end
endmodule // ddr3_spacing_host_tb
`default_nettype wire

// ### verif/ddr3_spacing_monitor.sv
// Checker for the DDR3 host: command spacing and strobe framing.
// Sees only the host's ports; bound to every host instance.
`timescale 1ns/1ps
`default_nettype none
`include "ddr3_spacing_defs.svh"

module ddr3_spacing_monitor #(
	parameter int CK_HALF = 2
)(
	input wire logic                   sys_clk,
	input wire logic                   resetn,
	input wire logic                   req_ready,
	input wire logic                   rd_valid,
	input wire ddr3_spacing_pkg::cmd_s cmd,
	input wire logic                   dqs_o,
	input wire logic                   dqs_oe,
	input wire logic                   dq_oe
);
	import ddr3_spacing_pkg::*;
	localparam int TCK = 2 * CK_HALF;
	logic [3:0] code;
	logic       mrs, col, act, rd;
	logic [7:0] mrs_r, col_r, act_r;
	logic [7:0] mrs_nxt, col_nxt, act_nxt;

	// Decode the command shown with each take
	assign code = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
	assign mrs = req_ready && code == `CMD_MRS;
	assign rd = req_ready && code == `CMD_RD;
	assign col = rd || (req_ready && code == `CMD_WR);
	assign act = req_ready && code == `CMD_ACT;

	// Saturating cycle counts since the last command of each kind
	always_comb
	begin
		mrs_nxt = mrs ? 8'h01 : mrs_r + 8'(mrs_r != 8'hff);
		col_nxt = col ? 8'h01 : col_r + 8'(col_r != 8'hff);
		act_nxt = act ? 8'h01 : act_r + 8'(act_r != 8'hff);
	end

	// Register the counts; reset means nothing blocked
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mrs_r <= 8'hff;
			col_r <= 8'hff;
			act_r <= 8'hff;
		end
		else
		begin
			mrs_r <= mrs_nxt;
			col_r <= col_nxt;
			act_r <= act_nxt;
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	mrs_gap_a: assert property (mrs |-> mrs_r >= TCK * `T_MRD_CK)
		else $error("mode commands too close");
	mod_wait_a: assert property ((req_ready && !mrs) |-> mrs_r >= TCK * `T_MOD_CK)
		else $error("command too soon after mode command");
	col_gap_a: assert property (col |-> col_r >= TCK * `T_CCD_CK)
		else $error("column commands too close");
	act_gap_a: assert property (act |-> act_r >= TCK * `T_RRD_CK)
		else $error("activates too close");
	wr_pre_a: assert property ($rose(dqs_oe) |-> (!dqs_o)[*4])
		else $error("write preamble too short");
	wr_post_a: assert property ($fell(dqs_oe) |-> !$past(dqs_o) && !$past(dqs_o, 2))
		else $error("write postamble too short");
	oe_pair_a: assert property (dq_oe == dqs_oe)
		else $error("data and strobe enables differ");
	rd_off_a: assert property (rd |-> (!dqs_oe)[*8] ##1 (!dqs_oe)[*8] ##1 (!dqs_oe)[*8])
		else $error("host drives strobe during read");
	rd_end_a: assert property (rd |-> ##[20:60] rd_valid)
		else $error("read burst not delivered");

	mrs_seen_c: cover property (mrs);
	act_seen_c: cover property (act);
	rd_seen_c: cover property (rd_valid);
endmodule // ddr3_spacing_monitor

bind ddr3_spacing_host ddr3_spacing_monitor #(.CK_HALF(CK_HALF)) mon (
	.sys_clk, .resetn, .req_ready, .rd_valid, .cmd, .dqs_o, .dqs_oe, .dq_oe
);
`default_nettype wire
